// >>> src/isa_pkg.sv
// What this block does
// RL1: Word/byte add, subtract, with carry; 2/4 bytes
// RL2: 16x16 product, signed or unsigned, 2 bytes
// RL3: Low product word divided by register, 16/16
// RL4: Full 32-bit pair divided by 16-bit register
// RL5: Bit copy, inverted copy, AND/OR/XOR; 4 bytes
// RL6: Masked byte modify from immediate; 4 bytes
// RL7: Compare, then pointer decrement/increment by 1/2
// RL8: Normalise count stored in another register
// RL9: Logical shifts, rotates, sign-fill right shift
// RL10: Byte to word, sign or zero fill
// RL11: Bit-test branches, optional clear or set
// RL12: Push register then absolute call; 4 bytes
// RL13: Push register then load it; 4 bytes
// RL14: Trap entry by immediate number; 2 bytes
// RL15: Legacy power-down decodes, 4 bytes, no action
// RL16: Every coprocessor instruction is 4 bytes
// RL17: Page/segment override prefix, optional register mode
// RL18: Length from opcode through loadable encoding table
// RL19: Addressing and conditions are decoder inputs
package isa_pkg;
  // Encoding table entry layout
  localparam int ENT_W = 8;
  localparam int ENT_VALID_BIT = 7;
  localparam int ENT_LEN4_BIT = 6;
  localparam int ENT_OP_MSB = 5;
  localparam int OPC_W = 8;
  localparam int TRAP_W = 7;
  // Pipeline depth from request to answer
  localparam int LATENCY = 2;
  // Pointer steps of the compare-with-update group
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  // Reset value of every output register
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] LONG_RST = 32'h00000000;

  // Operation classes held in the table
  typedef enum logic [5:0] {
    OP_NONE, OP_ADD, OP_SUM_CARRY, OP_SUB, OP_DIFF_BORROW,
    OP_PROD_S, OP_PROD_U, OP_DIV_S, OP_DIV_U, OP_LDIV_S, OP_LDIV_U,
    OP_BIT_COPY, OP_BIT_COPY_INV, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR,
    OP_FIELD_HI, OP_FIELD_LO, OP_CMP_DEC1, OP_CMP_DEC2, OP_CMP_INC1,
    OP_CMP_INC2, OP_NORM, OP_SHIFT_L, OP_SHIFT_R, OP_ROT_L, OP_ROT_R,
    OP_SIGN_SHR, OP_EXT_SIGN, OP_EXT_ZERO, OP_BR_SET, OP_BR_SET_CLR,
    OP_BR_CLR, OP_BR_CLR_SET, OP_PUSH_CALL, OP_CTX_SWITCH, OP_TRAP,
    OP_POWER_DOWN, OP_COPROC, OP_PAGE_PFX, OP_SEG_PFX
  } op_t;
endpackage

// >>> src/op_table_mem.sv
`timescale 1ns/1ps
// Opcode-to-class table; read data comes out of a register
module op_table_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  // Storage, no reset: software must load it before use
  logic [DW-1:0] mem_reg [2**AW];

  // Write side
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  // Registered read; same-cycle write returns the old entry
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem_reg[i_raddr];
    end
  end
endmodule

// >>> src/isa_exec.sv
`timescale 1ns/1ps
// Decodes one instruction per cycle and computes its effects
module isa_exec (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Encoding table load
  input wire logic i_tbl_we,
  input wire logic [7:0] i_tbl_addr,
  input wire logic [7:0] i_tbl_data,
  // Instruction request
  input wire logic i_valid,
  input wire logic [7:0] i_opcode,
  input wire logic i_byte,
  input wire logic i_carry,
  input wire logic i_ext_reg,
  // Operands
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  input wire logic [31:0] i_prod_full,
  input wire logic i_bit_src,
  input wire logic i_bit_dst,
  input wire logic [7:0] i_mask,
  input wire logic [7:0] i_imm,
  input wire logic [3:0] i_shift,
  // Answer status
  output logic o_valid,
  output logic o_illegal,
  output logic o_len4,
  output isa_pkg::op_t o_op,
  // Answer data
  output logic [15:0] o_result,
  output logic o_result_we,
  output logic [31:0] o_prod_full,
  output logic o_prod_we,
  output logic [15:0] o_ptr,
  output logic o_flag_c,
  output logic o_flag_z,
  output logic o_div_zero,
  output logic o_bit,
  output logic o_bit_we,
  // Control actions
  output logic o_branch,
  output logic o_push,
  output logic [15:0] o_push_data,
  output logic o_call,
  output logic o_trap,
  output logic [6:0] o_trap_num,
  output logic o_coproc,
  output logic o_page_pfx,
  output logic o_seg_pfx,
  output logic o_pfx_reg
);

  // Length from class; 2/4 classes follow the table bit
  function automatic logic len4_of(isa_pkg::op_t op, logic tbl);
    case (op)
      isa_pkg::OP_ADD, isa_pkg::OP_SUM_CARRY, isa_pkg::OP_SUB,
      isa_pkg::OP_DIFF_BORROW, isa_pkg::OP_CMP_DEC1,
      isa_pkg::OP_CMP_DEC2, isa_pkg::OP_CMP_INC1, isa_pkg::OP_CMP_INC2,
      isa_pkg::OP_EXT_SIGN, isa_pkg::OP_EXT_ZERO, isa_pkg::OP_PAGE_PFX,
      isa_pkg::OP_SEG_PFX: len4_of = tbl;
      isa_pkg::OP_BIT_COPY, isa_pkg::OP_BIT_COPY_INV,
      isa_pkg::OP_BIT_AND, isa_pkg::OP_BIT_OR, isa_pkg::OP_BIT_XOR,
      isa_pkg::OP_FIELD_HI, isa_pkg::OP_FIELD_LO, isa_pkg::OP_BR_SET,
      isa_pkg::OP_BR_SET_CLR, isa_pkg::OP_BR_CLR, isa_pkg::OP_BR_CLR_SET,
      isa_pkg::OP_PUSH_CALL, isa_pkg::OP_CTX_SWITCH,
      isa_pkg::OP_POWER_DOWN, isa_pkg::OP_COPROC: len4_of = 1'b1;
      default: len4_of = 1'b0;
    endcase
  endfunction

  // Leading zeros of a nonzero word; zero word gives zero
  function automatic logic [3:0] norm_count(logic [15:0] w);
    norm_count = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (w[i]) begin
        norm_count = 4'(15 - i);
      end
    end
  endfunction

  // Table entry comes back one cycle after the opcode
  logic [7:0] ent;

  op_table_mem #(.AW(isa_pkg::OPC_W), .DW(isa_pkg::ENT_W)) u_table (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(i_tbl_we),
    .i_waddr(i_tbl_addr),
    .i_wdata(i_tbl_data),
    .i_raddr(i_opcode),
    .o_rdata(ent)
  ); // RL18

  // Stage one holds operands beside the table read
  logic s1_valid_reg;
  logic s1_byte_reg, s1_c_reg, s1_xr_reg, s1_bs_reg, s1_bd_reg;
  logic [15:0] s1_a_reg, s1_b_reg;
  logic [31:0] s1_p_reg;
  logic [7:0] s1_mask_reg, s1_imm_reg;
  logic [3:0] s1_sh_reg;

  // Valid pipe is reset; the data pipe is reset too and loads only with i_valid
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_valid_reg <= 1'b0;
    end else begin
      s1_valid_reg <= i_valid;
    end
  end

  // Operand capture, modes stay inputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {s1_byte_reg, s1_c_reg, s1_xr_reg, s1_bs_reg, s1_bd_reg} <= 5'h00;
      {s1_a_reg, s1_b_reg} <= isa_pkg::LONG_RST;
      s1_p_reg <= isa_pkg::LONG_RST;
      {s1_mask_reg, s1_imm_reg} <= 16'h0000;
      s1_sh_reg <= 4'h0;
    end else if (i_valid) begin
      {s1_byte_reg, s1_c_reg, s1_xr_reg} <= {i_byte, i_carry, i_ext_reg};
      {s1_bs_reg, s1_bd_reg} <= {i_bit_src, i_bit_dst};
      {s1_a_reg, s1_b_reg} <= {i_a, i_b};
      s1_p_reg <= i_prod_full;
      {s1_mask_reg, s1_imm_reg} <= {i_mask, i_imm};
      s1_sh_reg <= i_shift;
    end // RL19
  end

  // Entry decode; classes past the last member are illegal
  wire [5:0] ent_op_raw = ent[isa_pkg::ENT_OP_MSB:0];
  wire ent_known = ent_op_raw <= 6'(isa_pkg::OP_SEG_PFX);
  wire ent_ok = ent[isa_pkg::ENT_VALID_BIT] && ent_known;
  wire isa_pkg::op_t op = ent_ok ? isa_pkg::op_t'(ent_op_raw) : isa_pkg::OP_NONE;
  wire len4 = len4_of(op, ent[isa_pkg::ENT_LEN4_BIT]); // RL18

  // Add and subtract, word and low byte
  wire cin = (op == isa_pkg::OP_SUM_CARRY || op == isa_pkg::OP_DIFF_BORROW)
             && s1_c_reg;
  wire [16:0] add_w = {1'b0, s1_a_reg} + {1'b0, s1_b_reg} + {16'h0000, cin};
  wire [16:0] sub_w = {1'b0, s1_a_reg} - {1'b0, s1_b_reg} - {16'h0000, cin};
  wire [8:0] add_b = {1'b0, s1_a_reg[7:0]} + {1'b0, s1_b_reg[7:0]} + {8'h00, cin};
  wire [8:0] sub_b = {1'b0, s1_a_reg[7:0]} - {1'b0, s1_b_reg[7:0]} - {8'h00, cin};

  // Products
  wire [31:0] prod_u = s1_a_reg * s1_b_reg;
  // Signed target keeps the full 32-bit signed product
  wire signed [31:0] prod_s = $signed(s1_a_reg) * $signed(s1_b_reg);

  // Divides; divisor zero blocks the write instead of trapping
  wire dz = s1_b_reg == isa_pkg::WORD_RST;
  wire [15:0] dvd = s1_p_reg[15:0];
  wire [31:0] dvs_u = {16'h0000, s1_b_reg};
  wire [31:0] dvs_s = {{16{s1_b_reg[15]}}, s1_b_reg};
  wire [15:0] q_u = dz ? 16'h0000 : dvd / s1_b_reg;
  wire [15:0] r_u = dz ? 16'h0000 : dvd % s1_b_reg;
  wire [15:0] q_s = dz ? 16'h0000 : 16'($signed(dvd) / $signed(s1_b_reg));
  wire [15:0] r_s = dz ? 16'h0000 : 16'($signed(dvd) % $signed(s1_b_reg));
  wire [31:0] lq_u = dz ? 32'h00000000 : s1_p_reg / dvs_u;
  wire [31:0] lr_u = dz ? 32'h00000000 : s1_p_reg % dvs_u;
  wire [31:0] lq_s = dz ? 32'h00000000 : 32'($signed(s1_p_reg) / $signed(dvs_s));
  wire [31:0] lr_s = dz ? 32'h00000000 : 32'($signed(s1_p_reg) % $signed(dvs_s));

  // Shifts and rotates by a 4-bit count
  wire [31:0] rot_l = {s1_a_reg, s1_a_reg} << s1_sh_reg;
  wire [31:0] rot_r = {s1_a_reg, s1_a_reg} >> s1_sh_reg;
  wire [15:0] sar = 16'($signed(s1_a_reg) >>> s1_sh_reg);

  // Masked byte field
  wire [7:0] fld_hi = (s1_a_reg[15:8] & ~s1_mask_reg) | (s1_imm_reg & s1_mask_reg);
  wire [7:0] fld_lo = (s1_a_reg[7:0] & ~s1_mask_reg) | (s1_imm_reg & s1_mask_reg);

  // Next values of the answer registers
  logic [15:0] res_next, ptr_next;
  logic [31:0] prod_next;
  logic res_we_next, prod_we_next, c_next, z_next, dz_next;
  logic bit_next, bit_we_next, br_next, push_next, call_next;
  logic trap_next, cop_next, pg_next, sg_next;

  // Operation dispatch
  always_comb begin
    res_next = s1_a_reg;
    ptr_next = s1_a_reg;
    prod_next = s1_p_reg;
    {res_we_next, prod_we_next, c_next, z_next, dz_next} = 5'h00;
    {bit_next, bit_we_next, br_next, push_next, call_next} = 5'h00;
    {trap_next, cop_next, pg_next, sg_next} = 4'h0;
    case (op)
      isa_pkg::OP_ADD, isa_pkg::OP_SUM_CARRY: begin
        res_we_next = 1'b1;
        if (s1_byte_reg) begin
          res_next = {s1_a_reg[15:8], add_b[7:0]};
          c_next = add_b[8];
        end else begin
          res_next = add_w[15:0];
          c_next = add_w[16];
        end // RL1
      end
      isa_pkg::OP_SUB, isa_pkg::OP_DIFF_BORROW: begin
        res_we_next = 1'b1;
        if (s1_byte_reg) begin
          res_next = {s1_a_reg[15:8], sub_b[7:0]};
          c_next = sub_b[8];
        end else begin
          res_next = sub_w[15:0];
          c_next = sub_w[16];
        end // RL1
      end
      isa_pkg::OP_PROD_S: begin
        prod_we_next = 1'b1;
        prod_next = prod_s; // RL2
      end
      isa_pkg::OP_PROD_U: begin
        prod_we_next = 1'b1;
        prod_next = prod_u; // RL2
      end
      isa_pkg::OP_DIV_S, isa_pkg::OP_DIV_U: begin
        dz_next = dz;
        prod_we_next = !dz;
        prod_next = (op == isa_pkg::OP_DIV_S) ? {r_s, q_s} : {r_u, q_u}; // RL3
      end
      isa_pkg::OP_LDIV_S, isa_pkg::OP_LDIV_U: begin
        dz_next = dz;
        prod_we_next = !dz;
        prod_next = (op == isa_pkg::OP_LDIV_S) ? {lr_s[15:0], lq_s[15:0]}
                                               : {lr_u[15:0], lq_u[15:0]}; // RL4
      end
      isa_pkg::OP_BIT_COPY: {bit_we_next, bit_next} = {1'b1, s1_bs_reg}; // RL5
      isa_pkg::OP_BIT_COPY_INV: {bit_we_next, bit_next} = {1'b1, !s1_bs_reg}; // RL5
      isa_pkg::OP_BIT_AND: {bit_we_next, bit_next} = {1'b1, s1_bd_reg & s1_bs_reg}; // RL5
      isa_pkg::OP_BIT_OR: {bit_we_next, bit_next} = {1'b1, s1_bd_reg | s1_bs_reg}; // RL5
      isa_pkg::OP_BIT_XOR: {bit_we_next, bit_next} = {1'b1, s1_bd_reg ^ s1_bs_reg}; // RL5
      isa_pkg::OP_FIELD_HI: {res_we_next, res_next} = {1'b1, fld_hi, s1_a_reg[7:0]}; // RL6
      isa_pkg::OP_FIELD_LO: {res_we_next, res_next} = {1'b1, s1_a_reg[15:8], fld_lo}; // RL6
      isa_pkg::OP_CMP_DEC1, isa_pkg::OP_CMP_DEC2,
      isa_pkg::OP_CMP_INC1, isa_pkg::OP_CMP_INC2: begin
        z_next = s1_a_reg == s1_b_reg;
        c_next = s1_a_reg < s1_b_reg;
        case (op)
          isa_pkg::OP_CMP_DEC1: ptr_next = s1_a_reg - isa_pkg::STEP_ONE;
          isa_pkg::OP_CMP_DEC2: ptr_next = s1_a_reg - isa_pkg::STEP_TWO;
          isa_pkg::OP_CMP_INC1: ptr_next = s1_a_reg + isa_pkg::STEP_ONE;
          default: ptr_next = s1_a_reg + isa_pkg::STEP_TWO;
        endcase // RL7
      end
      isa_pkg::OP_NORM: {res_we_next, res_next} = {1'b1, 12'h000, norm_count(s1_a_reg)}; // RL8
      isa_pkg::OP_SHIFT_L: {res_we_next, res_next} = {1'b1, 16'(s1_a_reg << s1_sh_reg)}; // RL9
      isa_pkg::OP_SHIFT_R: {res_we_next, res_next} = {1'b1, s1_a_reg >> s1_sh_reg}; // RL9
      isa_pkg::OP_ROT_L: {res_we_next, res_next} = {1'b1, rot_l[31:16]}; // RL9
      isa_pkg::OP_ROT_R: {res_we_next, res_next} = {1'b1, rot_r[15:0]}; // RL9
      isa_pkg::OP_SIGN_SHR: {res_we_next, res_next} = {1'b1, sar}; // RL9
      isa_pkg::OP_EXT_SIGN: begin
        res_we_next = 1'b1;
        res_next = {{8{s1_a_reg[7]}}, s1_a_reg[7:0]}; // RL10
      end
      isa_pkg::OP_EXT_ZERO: {res_we_next, res_next} = {1'b1, 8'h00, s1_a_reg[7:0]}; // RL10
      // Clear-on-taken and set-on-taken variants write the bit back
      isa_pkg::OP_BR_SET, isa_pkg::OP_BR_SET_CLR: begin
        br_next = s1_bs_reg;
        bit_we_next = s1_bs_reg && op == isa_pkg::OP_BR_SET_CLR;
        bit_next = 1'b0; // RL11
      end
      isa_pkg::OP_BR_CLR, isa_pkg::OP_BR_CLR_SET: begin
        br_next = !s1_bs_reg;
        bit_we_next = !s1_bs_reg && op == isa_pkg::OP_BR_CLR_SET;
        bit_next = 1'b1; // RL11
      end
      isa_pkg::OP_PUSH_CALL: {push_next, call_next} = 2'h3; // RL12
      isa_pkg::OP_CTX_SWITCH: begin
        push_next = 1'b1;
        {res_we_next, res_next} = {1'b1, s1_b_reg}; // RL13
      end
      isa_pkg::OP_TRAP: trap_next = 1'b1; // RL14
      isa_pkg::OP_POWER_DOWN: res_next = s1_a_reg; // RL15
      isa_pkg::OP_COPROC: cop_next = 1'b1; // RL16
      isa_pkg::OP_PAGE_PFX: pg_next = 1'b1; // RL17
      isa_pkg::OP_SEG_PFX: sg_next = 1'b1; // RL17
      default: res_next = s1_a_reg;
    endcase
  end

  // Answer registers; strobes only with a valid answer
  wire go = s1_valid_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {o_valid, o_illegal, o_len4} <= 3'h0;
      o_op <= isa_pkg::OP_NONE;
      {o_result, o_ptr, o_push_data} <= 48'h000000000000;
      o_prod_full <= isa_pkg::LONG_RST;
      {o_result_we, o_prod_we, o_flag_c, o_flag_z, o_div_zero} <= 5'h00;
      {o_bit, o_bit_we, o_branch, o_push, o_call} <= 5'h00;
      {o_trap, o_coproc, o_page_pfx, o_seg_pfx, o_pfx_reg} <= 5'h00;
      o_trap_num <= 7'h00;
    end else begin
      {o_valid, o_illegal, o_len4} <= {go, go && !ent_ok, go && len4}; // RL18
      o_op <= op;
      {o_result, o_ptr, o_push_data} <= {res_next, ptr_next, s1_a_reg};
      o_prod_full <= prod_next;
      o_result_we <= go && res_we_next;
      o_prod_we <= go && prod_we_next;
      {o_flag_c, o_flag_z, o_div_zero} <= {c_next, z_next, go && dz_next};
      {o_bit, o_bit_we} <= {bit_next, go && bit_we_next};
      {o_branch, o_push, o_call} <= {3{go}} & {br_next, push_next, call_next};
      {o_trap, o_coproc} <= {2{go}} & {trap_next, cop_next};
      {o_page_pfx, o_seg_pfx} <= {2{go}} & {pg_next, sg_next};
      o_pfx_reg <= go && (pg_next || sg_next) && s1_xr_reg; // RL17
      o_trap_num <= s1_imm_reg[isa_pkg::TRAP_W-1:0]; // RL14
    end
  end

  // Checks of the answer against the request two cycles back
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  answer_latency_a: assert property (i_valid |-> ##2 o_valid) // RL18
    else $error("answer not two cycles after request");
  word_add_a: assert property ( // RL1
    o_valid && o_op == isa_pkg::OP_SUM_CARRY && !$past(i_byte, 2)
    |-> {o_flag_c, o_result} == {1'b0, $past(i_a, 2)} + {1'b0, $past(i_b, 2)}
    + {16'h0000, $past(i_carry, 2)})
    else $error("sum with carry wrong");
  product_u_a: assert property (o_valid && o_op == isa_pkg::OP_PROD_U // RL2
    |-> o_prod_we && o_prod_full == $past(i_a, 2) * $past(i_b, 2))
    else $error("unsigned product wrong");
  divide_u_a: assert property (o_valid && o_op == isa_pkg::OP_DIV_U && !o_div_zero // RL3
    |-> o_prod_full[15:0] == $past(i_prod_full[15:0], 2) / $past(i_b, 2))
    else $error("unsigned quotient wrong");
  field_low_a: assert property (o_valid && o_op == isa_pkg::OP_FIELD_LO // RL6
    |-> o_result[7:0] == (($past(i_a[7:0], 2) & ~$past(i_mask, 2))
    | ($past(i_imm, 2) & $past(i_mask, 2))) && o_len4)
    else $error("masked field wrong");
  ptr_step_a: assert property (o_valid && o_op == isa_pkg::OP_CMP_DEC2 // RL7
    |-> o_ptr == $past(i_a, 2) - isa_pkg::STEP_TWO)
    else $error("pointer step wrong");
  norm_top_a: assert property (o_valid && o_op == isa_pkg::OP_NORM && $past(i_a, 2) != 0 // RL8
    |-> 16'($past(i_a, 2) << o_result[3:0]) >= 16'h8000)
    else $error("normalise count wrong");
  sign_fill_a: assert property (o_valid && o_op == isa_pkg::OP_SIGN_SHR // RL9
    |-> o_result[15] == $past(i_a[15], 2))
    else $error("sign fill lost");
  zero_ext_a: assert property (o_valid && o_op == isa_pkg::OP_EXT_ZERO // RL10
    |-> o_result == {8'h00, $past(i_a[7:0], 2)})
    else $error("zero extend wrong");
  branch_set_a: assert property (o_valid && o_op == isa_pkg::OP_BR_SET_CLR // RL11
    |-> o_branch == $past(i_bit_src, 2) && o_bit_we == o_branch && !o_bit)
    else $error("bit branch wrong");
  power_idle_a: assert property (o_valid && o_op == isa_pkg::OP_POWER_DOWN // RL15
    |-> o_len4 && !o_result_we && !o_prod_we && !o_branch && !o_push)
    else $error("legacy op acted");
  coproc_len_a: assert property (o_valid && o_op == isa_pkg::OP_COPROC // RL16
    |-> o_len4 && o_coproc)
    else $error("coprocessor length wrong");

  cov_long_div: cover property (o_valid && o_op == isa_pkg::OP_LDIV_S && !o_div_zero);
  cov_branch: cover property (o_branch ##2 o_valid && o_op == isa_pkg::OP_BR_SET_CLR);
  cov_prefix: cover property (o_page_pfx && o_pfx_reg);
  cov_illegal: cover property (o_illegal);
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and table load
  // Clock starts at zero so no false falling edge at time zero
  logic i_clk = 1'b0;
  logic i_rst_n, i_tbl_we;
  logic [7:0] i_tbl_addr, i_tbl_data;
  // Request and operands
  logic i_valid, i_byte, i_carry, i_ext_reg, i_bit_src, i_bit_dst;
  logic [7:0] i_opcode, i_mask, i_imm;
  logic [15:0] i_a, i_b;
  logic [31:0] i_prod_full;
  logic [3:0] i_shift;
  // Answer side
  logic o_valid, o_illegal, o_len4, o_result_we, o_prod_we, o_flag_c, o_flag_z, o_div_zero;
  logic o_bit, o_bit_we, o_branch, o_push, o_call, o_trap, o_coproc;
  logic o_page_pfx, o_seg_pfx, o_pfx_reg;
  isa_pkg::op_t o_op;
  logic [15:0] o_result, o_ptr, o_push_data;
  logic [31:0] o_prod_full;
  logic [6:0] o_trap_num;
  // Score keeping
  int n_errors, comparisons, cycles;

  isa_exec dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tbl_we(i_tbl_we), .i_tbl_addr(i_tbl_addr),
    .i_tbl_data(i_tbl_data), .i_valid(i_valid), .i_opcode(i_opcode), .i_byte(i_byte),
    .i_carry(i_carry), .i_ext_reg(i_ext_reg), .i_a(i_a), .i_b(i_b),
    .i_prod_full(i_prod_full), .i_bit_src(i_bit_src), .i_bit_dst(i_bit_dst),
    .i_mask(i_mask), .i_imm(i_imm), .i_shift(i_shift), .o_valid(o_valid),
    .o_illegal(o_illegal), .o_len4(o_len4), .o_op(o_op), .o_result(o_result),
    .o_result_we(o_result_we), .o_prod_full(o_prod_full), .o_prod_we(o_prod_we),
    .o_ptr(o_ptr), .o_flag_c(o_flag_c), .o_flag_z(o_flag_z), .o_div_zero(o_div_zero),
    .o_bit(o_bit), .o_bit_we(o_bit_we), .o_branch(o_branch), .o_push(o_push),
    .o_push_data(o_push_data), .o_call(o_call), .o_trap(o_trap), .o_trap_num(o_trap_num),
    .o_coproc(o_coproc), .o_page_pfx(o_page_pfx), .o_seg_pfx(o_seg_pfx),
    .o_pfx_reg(o_pfx_reg)
  );

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end

  // Compare one value, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Closing report and verdict
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One request; returns at the falling edge inside its answer cycle
  task automatic run(input isa_pkg::op_t op);
    i_opcode = 8'(op);
    i_valid = 1'b1;
    @(negedge i_clk);
    i_valid = 1'b0;
    @(negedge i_clk);
    chk(o_valid, 1);
  endtask

  // Expected length; table bit 6 follows opcode bit 0 in our load
  function automatic logic len_of(input isa_pkg::op_t op);
    case (op)
      isa_pkg::OP_BIT_COPY, isa_pkg::OP_BIT_COPY_INV, isa_pkg::OP_BIT_AND, isa_pkg::OP_BIT_OR,
      isa_pkg::OP_BIT_XOR, isa_pkg::OP_FIELD_HI, isa_pkg::OP_FIELD_LO, isa_pkg::OP_BR_SET,
      isa_pkg::OP_BR_SET_CLR, isa_pkg::OP_BR_CLR, isa_pkg::OP_BR_CLR_SET, isa_pkg::OP_PUSH_CALL,
      isa_pkg::OP_CTX_SWITCH, isa_pkg::OP_POWER_DOWN, isa_pkg::OP_COPROC: return 1'b1;
      isa_pkg::OP_ADD, isa_pkg::OP_SUM_CARRY, isa_pkg::OP_SUB, isa_pkg::OP_DIFF_BORROW,
      isa_pkg::OP_CMP_DEC1, isa_pkg::OP_CMP_DEC2, isa_pkg::OP_CMP_INC1, isa_pkg::OP_CMP_INC2,
      isa_pkg::OP_EXT_SIGN, isa_pkg::OP_EXT_ZERO, isa_pkg::OP_PAGE_PFX,
      isa_pkg::OP_SEG_PFX: return op[0];
      default: return 1'b0;
    endcase
  endfunction

  // Load every class but OP_NONE, an invalid entry and two unknown-class entries, then decode all but the last
  task automatic t_lengths();
    i_tbl_we = 1'b1;
    for (int k = 1; k <= 43; k++) begin
      i_tbl_addr = 8'(k);
      i_tbl_data = (k == 42) ? 8'h40 : (k > 40) ? 8'hFF : {1'b1, 1'(k), 6'(k)};
      @(negedge i_clk);
    end
    i_tbl_we = 1'b0;
    for (int k = 1; k <= 40; k++) begin
      run(isa_pkg::op_t'(k));
      chk(32'(o_op), k);
      chk(o_len4, len_of(isa_pkg::op_t'(k)));
      chk(o_illegal, 0);
    end
    for (int k = 41; k <= 42; k++) begin
      run(isa_pkg::op_t'(k));
      chk(o_illegal, 1);
      chk({o_len4, o_result_we, o_push}, 0);
    end
  endtask

  // Add and subtract, carry ignored where not used
  task automatic t_arith();
    i_a = 16'h0005; i_b = 16'h0002; i_carry = 1'b1;
    run(isa_pkg::OP_ADD); chk(o_result, 16'h0007);
    run(isa_pkg::OP_SUM_CARRY); chk(o_result, 16'h0008);
    run(isa_pkg::OP_DIFF_BORROW); chk({o_flag_c, o_result}, 17'h00002);
    i_carry = 1'b0; i_a = 16'h0001;
    run(isa_pkg::OP_SUB); chk({o_flag_c, o_result_we, o_result}, 18'h3FFFF);
    i_byte = 1'b1; i_a = 16'h12F0; i_b = 16'h0020;
    run(isa_pkg::OP_ADD); chk({o_flag_c, o_result}, 17'h11210);
    i_byte = 1'b0;
  endtask

  // Products and divides, including a zero divisor
  task automatic t_muldiv();
    i_a = 16'hFFFE; i_b = 16'h0003;
    run(isa_pkg::OP_PROD_S); chk(o_prod_full, 32'hFFFFFFFA); chk(o_prod_we, 1);
    run(isa_pkg::OP_PROD_U); chk(o_prod_full, 32'h0002FFFA);
    i_prod_full = 32'h55550064; i_b = 16'h0007;
    run(isa_pkg::OP_DIV_U); chk(o_prod_full, 32'h0002000E);
    i_prod_full = 32'h0000FFF9; i_b = 16'h0002;
    run(isa_pkg::OP_DIV_S); chk(o_prod_full, 32'hFFFFFFFD);
    i_prod_full = 32'h00010000;
    run(isa_pkg::OP_LDIV_U); chk(o_prod_full, 32'h00008000);
    i_prod_full = 32'hFFFFFFF9;
    run(isa_pkg::OP_LDIV_S); chk(o_prod_full, 32'hFFFFFFFD);
    i_b = 16'h0000;
    run(isa_pkg::OP_LDIV_U); chk({o_div_zero, o_prod_we}, 2'h2);
  endtask

  // Bit pairs and masked byte field
  task automatic t_bits();
    i_bit_src = 1'b1; i_bit_dst = 1'b0;
    run(isa_pkg::OP_BIT_COPY); chk({o_bit_we, o_bit}, 2'h3);
    run(isa_pkg::OP_BIT_COPY_INV); chk({o_bit_we, o_bit}, 2'h2);
    run(isa_pkg::OP_BIT_AND); chk(o_bit, 0);
    run(isa_pkg::OP_BIT_OR); chk(o_bit, 1);
    i_bit_dst = 1'b1;
    run(isa_pkg::OP_BIT_XOR); chk(o_bit, 0);
    i_a = 16'hA5C3; i_mask = 8'h0F; i_imm = 8'h3C;
    run(isa_pkg::OP_FIELD_HI); chk(o_result, 16'hACC3);
    run(isa_pkg::OP_FIELD_LO); chk(o_result, 16'hA5CC);
  endtask

  // Compare with pointer steps, normalise, shifts, byte extend
  task automatic t_word();
    i_a = 16'h0100; i_b = 16'h0200;
    run(isa_pkg::OP_CMP_DEC1); chk({o_flag_c, o_flag_z, o_ptr}, 18'h200FF);
    run(isa_pkg::OP_CMP_DEC2); chk(o_ptr, 16'h00FE);
    run(isa_pkg::OP_CMP_INC1); chk(o_ptr, 16'h0101);
    i_b = 16'h0100;
    run(isa_pkg::OP_CMP_INC2); chk({o_flag_c, o_flag_z, o_ptr}, 18'h10102);
    i_a = 16'h0010;
    run(isa_pkg::OP_NORM); chk(o_result, 16'h000B);
    i_a = 16'h0000;
    run(isa_pkg::OP_NORM); chk(o_result, 16'h0000);
    i_a = 16'h8421; i_shift = 4'h4;
    run(isa_pkg::OP_SHIFT_L); chk(o_result, 16'h4210);
    run(isa_pkg::OP_SHIFT_R); chk(o_result, 16'h0842);
    run(isa_pkg::OP_ROT_L); chk(o_result, 16'h4218);
    run(isa_pkg::OP_ROT_R); chk(o_result, 16'h1842);
    run(isa_pkg::OP_SIGN_SHR); chk(o_result, 16'hF842);
    i_a = 16'h1280;
    run(isa_pkg::OP_EXT_SIGN); chk(o_result, 16'hFF80);
    run(isa_pkg::OP_EXT_ZERO); chk(o_result, 16'h0080);
  endtask

  // Branches, stack actions, trap, power-down, coprocessor, prefixes
  task automatic t_ctrl();
    i_bit_src = 1'b0;
    run(isa_pkg::OP_BR_SET); chk({o_branch, o_bit_we}, 0);
    run(isa_pkg::OP_BR_CLR_SET); chk({o_branch, o_bit_we, o_bit}, 3'h7);
    i_bit_src = 1'b1;
    run(isa_pkg::OP_BR_SET_CLR); chk({o_branch, o_bit_we, o_bit}, 3'h6);
    run(isa_pkg::OP_BR_CLR); chk(o_branch, 0);
    i_a = 16'hBEEF; i_b = 16'h2222;
    run(isa_pkg::OP_PUSH_CALL); chk({o_push, o_call, o_push_data}, 18'h3BEEF);
    run(isa_pkg::OP_CTX_SWITCH); chk({o_push, o_call, o_push_data}, 18'h2BEEF);
    chk({o_result_we, o_result}, 17'h12222);
    i_imm = 8'h85;
    run(isa_pkg::OP_TRAP); chk({o_trap, o_trap_num}, 8'h85);
    run(isa_pkg::OP_POWER_DOWN);
    chk({o_illegal, o_result_we, o_push, o_call, o_trap, o_branch, o_coproc}, 0);
    run(isa_pkg::OP_COPROC); chk(o_coproc, 1);
    i_ext_reg = 1'b1;
    run(isa_pkg::OP_PAGE_PFX); chk({o_page_pfx, o_seg_pfx, o_pfx_reg}, 3'h5);
    i_ext_reg = 1'b0;
    run(isa_pkg::OP_SEG_PFX); chk({o_page_pfx, o_seg_pfx, o_pfx_reg}, 3'h2);
  endtask

  // Two requests on adjacent edges answer on adjacent edges
  task automatic t_back2back();
    i_a = 16'h0003; i_b = 16'h0001; i_carry = 1'b0;
    i_opcode = 8'(isa_pkg::OP_ADD); i_valid = 1'b1;
    @(negedge i_clk);
    i_opcode = 8'(isa_pkg::OP_SUB);
    @(negedge i_clk);
    i_valid = 1'b0;
    chk({o_valid, o_result}, 17'h10004);
    @(negedge i_clk);
    chk({o_valid, o_result}, 17'h10002);
    @(negedge i_clk);
    chk(o_valid, 0);
  endtask

  // Main sequence: inputs at zero, reset for four cycles, then scenarios
  initial begin
    {i_rst_n, i_tbl_we, i_tbl_addr, i_tbl_data, i_valid, i_opcode, i_byte} = '0;
    {i_carry, i_ext_reg, i_a, i_b, i_prod_full, i_bit_src, i_bit_dst} = '0;
    {i_mask, i_imm, i_shift} = '0;
    repeat (4) @(negedge i_clk);
    chk({o_valid, o_result_we, 32'(o_op)}, 0);
    i_rst_n = 1'b1;
    t_lengths();
    t_arith();
    t_muldiv();
    t_bits();
    t_word();
    t_ctrl();
    t_back2back();
    conclude();
  end
endmodule
